// [wgt_pkg.sv]
// shared constants, types and helpers for the waveform trigger control
`default_nettype none
package wgt_pkg;
	localparam int DW = 16;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MODE   = 8'h04;
	localparam logic [7:0] REG_OFFSET = 8'h08;
	localparam logic [7:0] REG_AMASK  = 8'h0c;
	localparam logic [7:0] REG_ASTAT  = 8'h10;
	localparam logic [7:0] REG_DMASK  = 8'h14;
	localparam logic [7:0] REG_DSTAT  = 8'h18;
	localparam logic [7:0] REG_DELAY  = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_STEP   = 8'h24;
	localparam int CTRL_INIT   = 0;
	localparam int CTRL_ABORT  = 1;
	localparam int CTRL_SWTRIG = 2;
	localparam int CTRL_OUTEN  = 3;
	localparam int MODE_OUT_LSB  = 0;
	localparam int MODE_TRIG_LSB = 4;
	localparam int MODE_SRC_LSB  = 8;
	localparam int MODE_SQUARE   = 12;
	localparam int MODE_LOWEND   = 13;
	localparam int DLY_MARK_LSB  = 0;
	localparam int DLY_START_LSB = 4;
	localparam int DLY_DONE_LSB  = 8;
	localparam logic [3:0] SRC_IMMED   = 4'h0;
	localparam logic [3:0] SRC_FRONT_A = 4'h1;
	localparam logic [3:0] SRC_FRONT_B = 4'h2;
	localparam logic [3:0] SRC_BP0     = 4'h3;
	localparam logic [3:0] SRC_STAR    = 4'hb;
	localparam logic [15:0] OFFSET_RST = 16'h8000;
	localparam logic [15:0] MASK_RST   = 16'hffff;
	localparam logic [15:0] STAT_RST   = 16'h0000;
	localparam logic [15:0] STEP_RST   = 16'h0010;
	localparam logic [11:0] DELAY_RST  = 12'h000;
	localparam logic [15:0] SQ_LOW     = 16'h0000;
	localparam int CLK_NS        = 100;
	localparam int EXP_PULSE_NS  = 150;
	localparam logic [3:0] EXP_PULSE_CYC =
		4'((EXP_PULSE_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [2:0] {OM_STD, OM_ARB, OM_SEQ, OM_SCRIPT, OM_FLIST}
		wgt_omode_t;
	typedef enum logic [1:0] {TM_SINGLE, TM_CONT, TM_STEPPED, TM_BURST}
		wgt_tmode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_PAUSE}
		wgt_state_t;
	function automatic logic [15:0] mask_apply(input logic [15:0] wave,
		input logic [15:0] mask, input logic [15:0] stat);
		return (wave & mask) | (stat & ~mask);
	endfunction
	function automatic logic reg_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= REG_STEP);
	endfunction
endpackage
`default_nettype wire

// [wgt_edge_sync.sv]
// two-flop synchroniser and rising edge detector for trigger inputs
`default_nettype none
module wgt_edge_sync #(
	parameter int W = 11
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
		logic [W-1:0] rise;
	} wgt_es_state_t;
	wgt_es_state_t s;
	wgt_es_state_t n;
	always_comb
	begin
		n = s;
		n.meta = async_in;
		n.sync = s.meta;
		n.prev = s.sync;
		n.rise = s.sync & ~s.prev;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end
	assign rise = s.rise;
	// a held high level gives one pulse only
	property p_one_pulse;
		@(posedge clk) disable iff (!rst_n)
		rise[0] |=> !rise[0];
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("edge detector pulsed twice");
endmodule
`default_nettype wire

// [wgt_evt_delay.sv]
// event delay line in whole sample clock periods
`default_nettype none
module wgt_evt_delay #(
	parameter int MAXD = 15
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ev_in,
	input  wire logic [3:0] dly,
	output logic            ev_out
);
	typedef struct packed {
		logic [MAXD-1:0] sr;
		logic            out;
	} wgt_ed_state_t;
	wgt_ed_state_t s;
	wgt_ed_state_t n;
	always_comb
	begin
		n = s;
		n.sr = {s.sr[MAXD-2:0], ev_in};
		if (dly == 4'h0)
			n.out = ev_in;
		else
			n.out = s.sr[dly - 4'h1];
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end
	assign ev_out = s.out;
	property p_dly2;
		@(posedge clk) disable iff (!rst_n)
		(ev_in && dly == 4'h2) ##1 (dly == 4'h2) [*2] |=> ev_out;
	endproperty
	a_dly2: assert property (p_dly2)
		else $error("event not two periods late");
endmodule
`default_nettype wire

// [wgt_ctrl.sv]
// waveform generator abort, trigger, data mask and event delay control
//
// Implementation choices: the placing of the registers and register access over APB.
`default_nettype none
module wgt_ctrl #(
	parameter int MAX_DLY = 15
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        front_trigger_in_a,
	input  wire logic        front_trigger_in_b,
	input  wire logic [7:0]  backplane_trigger_lines,
	input  wire logic        star_trigger_in,
	input  wire logic [15:0] wave_sample,
	input  wire logic        wave_marker,
	input  wire logic        wave_last,
	output logic      [15:0] dac_word,
	output logic      [15:0] digital_out,
	output logic             analog_output_enable,
	output logic             gen_run,
	output logic             step_advance,
	output logic             start_trig_out,
	output logic             marker_event,
	output logic             started_event,
	output logic             done_event
);
	typedef struct packed {
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
		wgt_pkg::wgt_omode_t omode;
		wgt_pkg::wgt_tmode_t tmode;
		logic [3:0]          src;
		logic                square;
		logic                lowend;
		logic                outen;
		logic [15:0]         offset;
		logic [15:0]         amask;
		logic [15:0]         astat;
		logic [15:0]         dmask;
		logic [15:0]         dstat;
		logic [11:0]         dly;
		logic [11:0]         dly_act;
		logic [15:0]         step_dur;
		logic [15:0]         step_cnt;
		wgt_pkg::wgt_state_t st;
		logic                imm_req;
		logic                pending;
		logic                aborted;
		logic                start_pend;
		logic [15:0]         dac;
		logic [15:0]         dig;
		logic                run;
		logic                step_adv;
		logic [3:0]          exp_cnt;
		logic                start_out;
	} wgt_ctrl_state_t;

	wgt_ctrl_state_t     s;
	wgt_ctrl_state_t     n;
	logic                rst_meta;
	logic                rst_n;
	logic [10:0]         rise;
	logic                wr_en;
	logic                do_init;
	logic                do_abort;
	logic                do_sw;
	logic                sel_rise;
	logic                trig;
	logic                step_end;
	logic                stream;
	logic                accept;
	logic                ev_mark;
	logic                ev_done;
	logic                abort_hit;
	wgt_pkg::wgt_tmode_t eff_tm;

	// reset released through two flops, asserted at once
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	wgt_edge_sync #(
		.W (11)
	) u_trig_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({star_trigger_in, backplane_trigger_lines,
			front_trigger_in_b, front_trigger_in_a}),
		.rise     (rise)
	);

	assign wr_en    = psel & penable & s.pready & pwrite;
	assign do_init  = wr_en & (paddr == wgt_pkg::REG_CTRL)
		& pwdata[wgt_pkg::CTRL_INIT];
	assign do_abort = wr_en & (paddr == wgt_pkg::REG_CTRL)
		& pwdata[wgt_pkg::CTRL_ABORT];
	assign do_sw    = wr_en & (paddr == wgt_pkg::REG_CTRL)
		& pwdata[wgt_pkg::CTRL_SWTRIG];
	// source index less one selects the bit of the synchronised edge vector
	assign sel_rise = (s.src != wgt_pkg::SRC_IMMED)
		&& (s.src <= wgt_pkg::SRC_STAR)
		&& rise[s.src - 4'h1];
	// immediate source: first pulse automatic, later ones by software
	assign trig = (s.src == wgt_pkg::SRC_IMMED) ? (s.imm_req | do_sw)
		: sel_rise;
	// trigger modes only shape arb, sequence and frequency list output
	assign eff_tm = (s.omode == wgt_pkg::OM_ARB
		|| s.omode == wgt_pkg::OM_SEQ || s.omode == wgt_pkg::OM_FLIST)
		? s.tmode : wgt_pkg::TM_CONT;
	assign step_end = (s.omode == wgt_pkg::OM_FLIST)
		? (s.step_cnt == 16'h0000) : wave_last;
	assign stream = (s.st == wgt_pkg::ST_RUN)
		|| (s.st == wgt_pkg::ST_PAUSE && eff_tm == wgt_pkg::TM_BURST);
	assign abort_hit = do_abort && (s.st != wgt_pkg::ST_IDLE);

	always_comb
	begin
		n = s;
		accept = 1'b0;
		ev_done = 1'b0;
		n.step_adv = 1'b0;
		n.imm_req = 1'b0;
		n.start_pend = 1'b0;
		n.pready = psel & ~penable;
		n.pslverr = psel & ~penable & ~wgt_pkg::reg_mapped(paddr);
		if (psel & ~penable)
		begin
			case (paddr)
			wgt_pkg::REG_CTRL:   n.prdata = {28'h0, s.outen, 3'h0};
			wgt_pkg::REG_MODE:   n.prdata = {18'h0, s.lowend, s.square,
				s.src, 2'h0, s.tmode, 1'h0, s.omode};
			wgt_pkg::REG_OFFSET: n.prdata = {16'h0, s.offset};
			wgt_pkg::REG_AMASK:  n.prdata = {16'h0, s.amask};
			wgt_pkg::REG_ASTAT:  n.prdata = {16'h0, s.astat};
			wgt_pkg::REG_DMASK:  n.prdata = {16'h0, s.dmask};
			wgt_pkg::REG_DSTAT:  n.prdata = {16'h0, s.dstat};
			wgt_pkg::REG_DELAY:  n.prdata = {20'h0, s.dly};
			wgt_pkg::REG_STATUS: n.prdata = {28'h0, s.aborted, s.pending,
				s.st};
			wgt_pkg::REG_STEP:   n.prdata = {16'h0, s.step_dur};
			default:             n.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_en)
		begin
			case (paddr)
			wgt_pkg::REG_CTRL:   n.outen = pwdata[wgt_pkg::CTRL_OUTEN];
			wgt_pkg::REG_MODE:
			begin
				n.omode  = wgt_pkg::wgt_omode_t'(pwdata[2:0]);
				n.tmode  = wgt_pkg::wgt_tmode_t'(pwdata[5:4]);
				n.src    = pwdata[11:8];
				n.square = pwdata[wgt_pkg::MODE_SQUARE];
				n.lowend = pwdata[wgt_pkg::MODE_LOWEND];
			end
			wgt_pkg::REG_OFFSET: n.offset = pwdata[15:0];
			wgt_pkg::REG_AMASK:  n.amask = pwdata[15:0];
			wgt_pkg::REG_ASTAT:  n.astat = pwdata[15:0];
			wgt_pkg::REG_DMASK:  n.dmask = pwdata[15:0];
			wgt_pkg::REG_DSTAT:  n.dstat = pwdata[15:0];
			wgt_pkg::REG_DELAY:  n.dly = pwdata[11:0];
			wgt_pkg::REG_STEP:   n.step_dur = pwdata[15:0];
			default:             n.offset = s.offset;
			endcase
		end
		case (s.st)
		wgt_pkg::ST_IDLE:
		begin
			// nothing listens to triggers here
			if (do_init)
			begin
				n.st = wgt_pkg::ST_ARMED;
				n.dly_act = s.dly;
				n.imm_req = (s.src == wgt_pkg::SRC_IMMED);
				n.pending = 1'b0;
				n.aborted = 1'b0;
			end
		end
		wgt_pkg::ST_ARMED:
		begin
			if (trig)
			begin
				accept = 1'b1;
				n.start_pend = 1'b1;
				n.st = wgt_pkg::ST_RUN;
				n.step_cnt = s.step_dur;
				n.step_adv = 1'b1;
			end
		end
		wgt_pkg::ST_RUN:
		begin
			if (s.step_cnt != 16'h0000)
				n.step_cnt = s.step_cnt - 16'h0001;
			if (step_end)
			begin
				case (eff_tm)
				wgt_pkg::TM_SINGLE:
				begin
					n.st = wgt_pkg::ST_IDLE;
					ev_done = 1'b1;
				end
				wgt_pkg::TM_CONT:
				begin
					n.step_cnt = s.step_dur;
					n.step_adv = 1'b1;
				end
				default:
				begin
					if (s.pending | trig)
					begin
						accept = 1'b1;
						n.step_cnt = s.step_dur;
						n.step_adv = 1'b1;
						n.pending = 1'b0;
					end
					else
						n.st = wgt_pkg::ST_PAUSE;
				end
				endcase
			end
			else if (trig && (eff_tm == wgt_pkg::TM_STEPPED
				|| eff_tm == wgt_pkg::TM_BURST))
				n.pending = 1'b1;
		end
		wgt_pkg::ST_PAUSE:
		begin
			if (trig)
			begin
				accept = 1'b1;
				n.st = wgt_pkg::ST_RUN;
				n.step_cnt = s.step_dur;
				n.step_adv = 1'b1;
			end
		end
		default: n.st = wgt_pkg::ST_IDLE;
		endcase
		// abort beats any trigger seen in the same cycle
		if (abort_hit)
		begin
			accept = 1'b0;
			ev_done = 1'b1;
			n.start_pend = 1'b0;
			n.step_adv = 1'b0;
			n.st = wgt_pkg::ST_IDLE;
			n.aborted = 1'b1;
			n.pending = 1'b0;
		end
		// two cycles after accept, two periods wide covers the minimum width
		n.exp_cnt = accept ? wgt_pkg::EXP_PULSE_CYC
			: (s.exp_cnt != 4'h0) ? s.exp_cnt - 4'h1 : 4'h0;
		n.start_out = (s.exp_cnt != 4'h0);
		n.run = (n.st == wgt_pkg::ST_RUN) || (n.st == wgt_pkg::ST_PAUSE
			&& eff_tm == wgt_pkg::TM_BURST);
		ev_mark = stream & wave_marker;
		if (abort_hit)
		begin
			if (s.omode == wgt_pkg::OM_STD && s.square && s.lowend)
				n.dac = wgt_pkg::SQ_LOW;
			else if (s.omode == wgt_pkg::OM_STD
				|| s.omode == wgt_pkg::OM_FLIST)
				n.dac = s.offset;
			else
				n.dac = s.dac;
		end
		else if (stream)
		begin
			n.dac = wgt_pkg::mask_apply(wave_sample, s.amask,
				s.astat);
			n.dig = wgt_pkg::mask_apply(wave_sample, s.dmask,
				s.dstat);
		end
		else if (s.st == wgt_pkg::ST_PAUSE && s.omode == wgt_pkg::OM_FLIST)
			n.dac = s.offset;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s          <= '0;
			s.offset   <= wgt_pkg::OFFSET_RST;
			s.amask    <= wgt_pkg::MASK_RST;
			s.astat    <= wgt_pkg::STAT_RST;
			s.dmask    <= wgt_pkg::MASK_RST;
			s.dstat    <= wgt_pkg::STAT_RST;
			s.dly      <= wgt_pkg::DELAY_RST;
			s.dly_act  <= wgt_pkg::DELAY_RST;
			s.step_dur <= wgt_pkg::STEP_RST;
		end
		else
			s <= n;
	end

	// one delay line per event, one terminal each, so it sets the phase
	wgt_evt_delay #(.MAXD (MAX_DLY)) u_dly_mark (
		.clk    (clk),
		.rst_n  (rst_n),
		.ev_in  (ev_mark),
		.dly    (s.dly_act[3:0]),
		.ev_out (marker_event)
	);
	wgt_evt_delay #(.MAXD (MAX_DLY)) u_dly_start (
		.clk    (clk),
		.rst_n  (rst_n),
		.ev_in  (s.start_pend),
		.dly    (s.dly_act[7:4]),
		.ev_out (started_event)
	);
	wgt_evt_delay #(.MAXD (MAX_DLY)) u_dly_done (
		.clk    (clk),
		.rst_n  (rst_n),
		.ev_in  (ev_done),
		.dly    (s.dly_act[11:8]),
		.ev_out (done_event)
	);

	assign prdata               = s.prdata;
	assign pready               = s.pready;
	assign pslverr              = s.pslverr;
	assign dac_word             = s.dac;
	assign digital_out          = s.dig;
	assign analog_output_enable = s.outen;
	assign gen_run              = s.run;
	assign step_advance         = s.step_adv;
	assign start_trig_out       = s.start_out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_abort_offset;
		(abort_hit && (s.omode == wgt_pkg::OM_FLIST
		|| (s.omode == wgt_pkg::OM_STD && !s.square))) |=> dac_word == s.offset;
	endproperty
	a_abort_offset: assert property (p_abort_offset)
		else $error("abort did not hold offset");
	property p_abort_hold;
		(abort_hit && s.omode == wgt_pkg::OM_ARB) |=> $stable(dac_word);
	endproperty
	a_abort_hold: assert property (p_abort_hold)
		else $error("abort did not hold last sample");
	property p_abort_sq;
		(abort_hit && s.omode == wgt_pkg::OM_STD && s.square && s.lowend)
		|=> dac_word == wgt_pkg::SQ_LOW;
	endproperty
	a_abort_sq: assert property (p_abort_sq)
		else $error("square did not drop low");
	property p_idle_deaf;
		(s.st == wgt_pkg::ST_IDLE) |=> s.st != wgt_pkg::ST_RUN;
	endproperty
	a_idle_deaf: assert property (p_idle_deaf)
		else $error("trigger accepted before initiate");
	property p_immediate;
		(do_init && !do_abort && s.st == wgt_pkg::ST_IDLE
		&& s.src == wgt_pkg::SRC_IMMED) |=> accept || do_abort;
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("no immediate start pulse");
	property p_export;
		accept |-> ##2 start_trig_out [*2];
	endproperty
	a_export: assert property (p_export)
		else $error("exported start too short or late");
	property p_amask;
		(stream && !abort_hit) |=> dac_word == (($past(wave_sample)
			& s.amask) | (s.astat & ~s.amask));
	endproperty
	a_amask: assert property (p_amask)
		else $error("analog mask wrong");
	property p_dmask;
		(stream && !abort_hit) |=> digital_out == (($past(wave_sample)
			& s.dmask) | (s.dstat & ~s.dmask));
	endproperty
	a_dmask: assert property (p_dmask)
		else $error("digital mask wrong");
	property p_pend;
		(s.st == wgt_pkg::ST_RUN && !step_end && trig && !abort_hit
		&& eff_tm == wgt_pkg::TM_STEPPED) |=> s.pending;
	endproperty
	a_pend: assert property (p_pend)
		else $error("step trigger lost");
	c_start: cover property (accept ##[1:20] done_event);
	c_abort: cover property (abort_hit);
	c_pause: cover property (s.st == wgt_pkg::ST_PAUSE ##1
		s.st == wgt_pkg::ST_RUN);
endmodule
`default_nettype wire

// [wgt_trig_src.sv]
// external trigger source model driving one selected trigger pin
`default_nettype none
module wgt_trig_src (
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic [3:0] sel,
	output logic            tfa,
	output logic            tfb,
	output logic [7:0]      bp,
	output logic            star
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle pins sit low as if pulled down; the chosen pin follows fire
	always_ff @(posedge clk)
	begin
		tfa <= fire && sel == 4'h1;
		tfb <= fire && sel == 4'h2;
		star <= fire && sel == 4'hb;
		for (int i = 0; i < 8; i++)
			bp[i] <= fire && sel == 4'(i + 3);
	end
endmodule
`default_nettype wire

// [waveform_gen_trigger_abort_ctrl_tb.sv]
// self-checking bench for the waveform trigger and abort control
`default_nettype none
module waveform_gen_trigger_abort_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fire;
	logic [3:0]  fsel;
	logic        tfa;
	logic        tfb;
	logic [7:0]  bp;
	logic        star;
	logic [15:0] wave;
	logic [15:0] dac_word;
	logic [15:0] digital_out;
	logic        aoe;
	logic        step_advance;
	logic        start_trig_out;
	logic        started_event;
	logic        done_event;
	logic        mark;
	logic        last;
	logic        run;
	logic        mark_ev;
	logic [31:0] rd;
	logic        er;
	int          miscompares;
	int          total_checks;
	int          wn;
	int          n;

	wgt_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .front_trigger_in_a(tfa),
		.front_trigger_in_b(tfb), .backplane_trigger_lines(bp),
		.star_trigger_in(star), .wave_sample(wave), .wave_marker(mark),
		.wave_last(last), .dac_word(dac_word), .digital_out(digital_out),
		.analog_output_enable(aoe), .gen_run(run), .step_advance(step_advance),
		.start_trig_out(start_trig_out), .marker_event(mark_ev),
		.started_event(started_event), .done_event(done_event));

	wgt_trig_src src (.clk(clk), .fire(fire), .sel(fsel), .tfa(tfa),
		.tfb(tfb), .bp(bp), .star(star));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task close_out;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			miscompares++;
		end
	endtask

	task tmo(input string nm);
		miscompares++;
		$display("[ERR] %s exp 1 got 0", nm);
		close_out();
	endtask

	// request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			tmo("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return step_advance;
			1: return start_trig_out;
			2: return started_event;
			4: return mark_ev;
			default: return done_event;
		endcase
	endfunction

	task waitfor(input int k, input int lim);
		// look first: a one-cycle event may stand as the call begins
		wn = 0;
		while (sig(k) !== 1'b1 && wn < lim)
		begin
			@(posedge clk);
			wn++;
		end
		if (sig(k) !== 1'b1)
			tmo("event");
	endtask

	task count(input int k, input int cyc);
		logic p;
		n = 0;
		p = 1'b0;
		repeat (cyc)
		begin
			@(posedge clk);
			if (sig(k) === 1'b1 && !p)
				n++;
			p = (sig(k) === 1'b1);
		end
	endtask

	task go(input logic [31:0] m);
		wr(wgt_pkg::REG_MODE, m);
		wr(wgt_pkg::REG_CTRL, 32'h9);
	endtask

	task stop(input logic [31:0] c);
		wr(wgt_pkg::REG_CTRL, c);
		waitfor(3, 40);
	endtask

	task pulse(input int s, input int h);
		fsel <= 4'(s);
		fire <= 1'b1;
		repeat (h) @(posedge clk);
		fire <= 1'b0;
		@(posedge clk);
	endtask

	task t_regs;
		apb(1'b0, wgt_pkg::REG_OFFSET, 32'h0);
		chk("offset", 32'h8000, rd);
		apb(1'b0, wgt_pkg::REG_AMASK, 32'h0);
		chk("amask", 32'hffff, rd);
		apb(1'b0, wgt_pkg::REG_STEP, 32'h0);
		chk("step", 32'h10, rd);
		apb(1'b1, 8'h0a, 32'h1234);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b0, wgt_pkg::REG_OFFSET, 32'h0);
		chk("offset kept", 32'h8000, rd);
		$display("test regs done");
	endtask

	task t_gate;
		int w;
		wr(wgt_pkg::REG_MODE, 32'h101);
		fsel <= 4'h1;
		fire <= 1'b1;
		// early edge must clear the synchroniser while still idle
		repeat (5) @(posedge clk);
		wr(wgt_pkg::REG_CTRL, 32'h9);
		count(0, 8);
		chk("early edge", 32'h0, n);
		fire <= 1'b0;
		count(0, 8);
		chk("fall", 32'h0, n);
		pulse(1, 3);
		waitfor(0, 12);
		waitfor(1, 8);
		w = 1;
		while (w < 10)
		begin
			@(posedge clk);
			if (start_trig_out !== 1'b1)
				break;
			w++;
		end
		chk("export width", 32'h1, {31'h0, w >= wgt_pkg::EXP_PULSE_CYC});
		stop(32'ha);
		$display("test gate done");
	endtask

	task t_srcs;
		for (int s = 1; s <= 11; s++)
		begin
			go(32'h1 | (32'(s) << 8));
			pulse(s % 11 + 1, 3);
			count(0, 12);
			chk("other source", 32'h0, n);
			pulse(s, 3);
			waitfor(0, 12);
			stop(32'ha);
		end
		$display("test sources done");
	endtask

	task t_imm;
		go(32'h11);
		count(1, 30);
		chk("immediate starts", 32'h1, n);
		stop(32'ha);
		pulse(2, 2);
		go(32'h224);
		pulse(2, 2);
		waitfor(0, 12);
		pulse(2, 2);
		pulse(2, 2);
		count(0, 40);
		chk("pending steps", 32'h1, n);
		stop(32'ha);
		$display("test trigger modes done");
	endtask

	task t_abort;
		logic [31:0] m [3];
		logic [15:0] e [3];
		m = '{32'h10, 32'h11, 32'h3010};
		e = '{16'h3c5a, 16'h0777, 16'h0000};
		wr(wgt_pkg::REG_OFFSET, 32'h3c5a);
		for (int i = 0; i < 3; i++)
		begin
			wave <= 16'h0777;
			go(m[i]);
			repeat (6) @(posedge clk);
			// relay opened first so the output can reach ground
			if (i == 2)
				wr(wgt_pkg::REG_CTRL, 32'h0);
			stop(i == 2 ? 32'h2 : 32'ha);
			wave <= 16'h0111;
			repeat (3) @(posedge clk);
			chk("abort level", {16'h0, e[i]}, {16'h0, dac_word});
			chk("out enable", {31'h0, i != 2}, {31'h0, aoe});
		end
		$display("test abort done");
	endtask

	task t_mask;
		wr(wgt_pkg::REG_AMASK, 32'hff00);
		wr(wgt_pkg::REG_ASTAT, 32'haaaa);
		wr(wgt_pkg::REG_DMASK, 32'h00ff);
		wr(wgt_pkg::REG_DSTAT, 32'h5555);
		wave <= 16'h1111;
		go(32'h11);
		repeat (8) @(posedge clk);
		chk("dac mask", 32'h11aa, {16'h0, dac_word});
		chk("digital mask", 32'h5511, {16'h0, digital_out});
		stop(32'ha);
		$display("test mask done");
	endtask

	task t_delay;
		int s0;
		int d0;
		for (int d = 0; d <= 2; d += 2)
		begin
			wr(wgt_pkg::REG_DELAY, 32'(d) * 32'h110);
			go(32'h01);
			waitfor(2, 40);
			if (d == 0)
				s0 = wn;
			else
				chk("started pair", 32'(s0 + 2), 32'(wn));
			// rewritten mid-run; the value taken at start must stay
			wr(wgt_pkg::REG_DELAY, 32'h0);
			stop(32'ha);
			if (d == 0)
				d0 = wn;
		end
		chk("done delay", 32'(d0 + 2), 32'(wn));
		wr(wgt_pkg::REG_DELAY, 32'h20);
		go(32'h01);
		waitfor(2, 40);
		chk("started delay", 32'(s0 + 2), 32'(wn));
		stop(32'ha);
		$display("test delay done");
	endtask

	task t_marker;
		wr(wgt_pkg::REG_DELAY, 32'h002);
		go(32'h01);
		repeat (2) @(posedge clk);
		chk("run", 32'h1, {31'h0, run});
		mark <= 1'b1;
		@(posedge clk);
		mark <= 1'b0;
		waitfor(4, 12);
		// delay 0 lands with the dac word one edge on, so 1 plus 2
		chk("marker delay", 32'h3, 32'(wn));
		last <= 1'b1;
		@(posedge clk);
		last <= 1'b0;
		waitfor(3, 12);
		chk("run after done", 32'h0, {31'h0, run});
		$display("test marker done");
	endtask

	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 1'b0;
		fsel = 4'h0;
		wave = 16'h0000;
		mark = 1'b0;
		last = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_gate();
		t_srcs();
		t_imm();
		t_abort();
		t_mask();
		t_delay();
		t_marker();
		close_out();
	end
endmodule
`default_nettype wire
